// ===== logic/smi_pkg.sv
// Operation
// - Memory-type code 02 means extended-data-out memory, 04 means synchronous DRAM, anything else is flagged unknown.
// - With one row group or two identical groups, row byte bits 3:0 give the row count and bits 7:4 read zero.
// - With unlike row groups, row byte bits 3:0 give group one and bits 7:4 give group two.
// - The reported row width never includes the bank-select lines.
// - Nibble codes 1 to 3 mean 16 to 18 bits, 0 is undefined, and 4 to F mean 4 to 15 bits directly.
// - With one row group or two identical groups, column byte bits 3:0 give the column count and bits 7:4 are zero.
// - With unlike row groups, column byte bits 3:0 give group one and bits 7:4 give group two.
// - The reported column width excludes the bank-select lines and the auto-precharge bit.
// - The module-rows byte is a plain count from 01 to FF, with 00 reported undefined.
// - Module data width is 16 bits, low byte from the lower index and high byte from the next, zero undefined.
// - Interface level codes 00 to 04 are 5 V TTL, LVTTL, HSTL 1.5, SSTL 3.3 and SSTL 2.5, FF is new table, others reserved.
// - Minimum clock period is high nibble nanoseconds plus low nibble tenths.
// - Maximum data-out delay is decoded with the same nanosecond and tenth split.
// - The configuration-type byte is kept as an eight-bit error-scheme code.
package smi_pkg;

	// ==========================================================
	// Byte indices
	localparam logic [7:0] SMI_IDX_MEM_TYPE  = 8'h02;
	localparam logic [7:0] SMI_IDX_ROW_ADDR  = 8'h03;
	localparam logic [7:0] SMI_IDX_COL_ADDR  = 8'h04;
	localparam logic [7:0] SMI_IDX_ROWS      = 8'h05;
	localparam logic [7:0] SMI_IDX_WIDTH_LO  = 8'h06;
	localparam logic [7:0] SMI_IDX_WIDTH_HI  = 8'h07;
	localparam logic [7:0] SMI_IDX_LEVEL     = 8'h08;
	localparam logic [7:0] SMI_IDX_CYCLE     = 8'h09;
	localparam logic [7:0] SMI_IDX_ACCESS    = 8'h0A;
	localparam logic [7:0] SMI_IDX_ERR_CFG   = 8'h0B;
	localparam int         SMI_NUM_BYTES     = 10;

	// ==========================================================
	// Code values
	localparam logic [7:0] SMI_TYPE_EDO      = 8'h02;
	localparam logic [7:0] SMI_TYPE_SDRAM    = 8'h04;
	localparam logic [7:0] SMI_LEVEL_NEW_TBL = 8'hFF;
	localparam logic [3:0] SMI_ROLLUP_MAX    = 4'h3;
	localparam logic [4:0] SMI_ROLLUP_BASE   = 5'h0F;
	localparam logic [7:0] SMI_TENTHS_PER_NS = 8'h0A;

	// ==========================================================
	// AXI4-Lite byte addresses
	localparam logic [7:0] SMI_ADDR_BYTES0   = 8'h00;
	localparam logic [7:0] SMI_ADDR_BYTES1   = 8'h04;
	localparam logic [7:0] SMI_ADDR_BYTES2   = 8'h08;
	localparam logic [7:0] SMI_ADDR_ROWCOL   = 8'h0C;
	localparam logic [7:0] SMI_ADDR_DECODE   = 8'h10;
	localparam logic [7:0] SMI_ADDR_TIMING   = 8'h14;
	localparam logic [7:0] SMI_ADDR_CTRL     = 8'h18;
	localparam logic [1:0] SMI_RESP_OKAY     = 2'b00;
	localparam logic [1:0] SMI_RESP_SLVERR   = 2'b10;
	localparam logic [9:0] SMI_RESET_MASK    = 10'h000;

	typedef enum logic [2:0]
	{
		SMI_LVL_TTL5     = 3'b000,
		SMI_LVL_LVTTL    = 3'b001,
		SMI_LVL_HSTL15   = 3'b010,
		SMI_LVL_SSTL33   = 3'b011,
		SMI_LVL_SSTL25   = 3'b100,
		SMI_LVL_NEW_TBL  = 3'b101,
		SMI_LVL_RESERVED = 3'b110
	} smi_level_e;

endpackage : smi_pkg

// ===== logic/smi_decoder.sv
module smi_decoder
	import smi_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// Fetched byte stream
	input  wire logic        byte_valid_i,
	input  wire logic [7:0]  byte_index_i,
	input  wire logic [7:0]  byte_data_i,
	// Decoded results
	output logic             done_o,
	output logic             type_edo_o,
	output logic             type_sdram_o,
	output logic             type_unknown_o,
	output logic [4:0]       row_bits_g1_o,
	output logic [4:0]       row_bits_g2_o,
	output logic [4:0]       col_bits_g1_o,
	output logic [4:0]       col_bits_g2_o,
	output logic             groups_differ_o,
	output logic [7:0]       module_rows_o,
	output logic             rows_undefined_o,
	output logic [15:0]      data_width_o,
	output logic             width_undefined_o,
	output logic [2:0]       signal_level_o,
	output logic [7:0]       min_period_tenths_o,
	output logic [7:0]       max_access_tenths_o,
	output logic [7:0]       error_scheme_o,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ==========================================================
	// Helpers
	// Nibble to address bit count; 0 stays 0 as the undefined marker
	function automatic logic [4:0] smi_addr_bits(input logic [3:0] nib);
		if (nib == 4'h0)
			return 5'h00;
		else if (nib <= SMI_ROLLUP_MAX)
			return SMI_ROLLUP_BASE + {1'b0, nib};
		else
			return {1'b0, nib};
	endfunction : smi_addr_bits

	// Nibble-split time to tenths of a nanosecond
	function automatic logic [7:0] smi_tenths(input logic [7:0] b);
		logic [11:0] prod;
		prod = {8'h00, b[7:4]} * {4'h0, SMI_TENTHS_PER_NS};
		return prod[7:0] + {4'h0, b[3:0]};
	endfunction : smi_tenths

	// ==========================================================
	// State
	typedef struct packed
	{
		logic [7:0]  mem_type;
		logic [7:0]  row_byte;
		logic [7:0]  col_byte;
		logic [7:0]  rows;
		logic [7:0]  width_lo;
		logic [7:0]  width_hi;
		logic [7:0]  level;
		logic [7:0]  cycle;
		logic [7:0]  access;
		logic [7:0]  err_cfg;
		logic [9:0]  seen;
		logic        done;
		logic        type_edo;
		logic        type_sdram;
		logic        type_unknown;
		logic [4:0]  row_g1;
		logic [4:0]  row_g2;
		logic [4:0]  col_g1;
		logic [4:0]  col_g2;
		logic        differ;
		logic        rows_undef;
		logic [15:0] width;
		logic        width_undef;
		logic [2:0]  level_code;
		logic [7:0]  period;
		logic [7:0]  acc_t;
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        aw_rdy;
		logic        w_rdy;
		logic        ar_rdy;
	} smi_state_s;

	// Readies idle high in reset so the bus sees a free slave at once
	localparam smi_state_s SMI_STATE_RST = '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};

	smi_state_s state_reg;
	smi_state_s state_next;

	always_comb
	begin
		logic [9:0]  seen_v;
		logic [9:0]  hit_v;
		logic [15:0] width_v;
		logic [3:0]  row_hi;
		logic [3:0]  col_hi;
		seen_v = '0;
		hit_v = '0;
		width_v = '0;
		row_hi = '0;
		col_hi = '0;
		state_next = state_reg;

		// ======================================================
		// Byte capture
		if (byte_valid_i)
		begin
			case (byte_index_i)
				SMI_IDX_MEM_TYPE: state_next.mem_type = byte_data_i;
				SMI_IDX_ROW_ADDR: state_next.row_byte = byte_data_i;
				SMI_IDX_COL_ADDR: state_next.col_byte = byte_data_i;
				SMI_IDX_ROWS:     state_next.rows = byte_data_i;
				SMI_IDX_WIDTH_LO: state_next.width_lo = byte_data_i;
				SMI_IDX_WIDTH_HI: state_next.width_hi = byte_data_i;
				SMI_IDX_LEVEL:    state_next.level = byte_data_i;
				SMI_IDX_CYCLE:    state_next.cycle = byte_data_i;
				SMI_IDX_ACCESS:   state_next.access = byte_data_i;
				SMI_IDX_ERR_CFG:  state_next.err_cfg = byte_data_i;
				default:          state_next.mem_type = state_reg.mem_type;
			endcase
			if (byte_index_i >= SMI_IDX_MEM_TYPE && byte_index_i <= SMI_IDX_ERR_CFG)
				hit_v[4'(byte_index_i - SMI_IDX_MEM_TYPE)] = 1'b1;
		end
		state_next.seen = state_reg.seen | hit_v;
		seen_v = state_next.seen;
		state_next.done = &seen_v;

		// ======================================================
		// Decode, registered one cycle after capture
		state_next.type_edo = (state_reg.mem_type == SMI_TYPE_EDO);
		state_next.type_sdram = (state_reg.mem_type == SMI_TYPE_SDRAM);
		state_next.type_unknown = !state_next.type_edo && !state_next.type_sdram;

		// Counts exclude bank selects and auto-precharge by construction of the byte
		row_hi = state_reg.row_byte[7:4];
		col_hi = state_reg.col_byte[7:4];
		state_next.row_g1 = smi_addr_bits(state_reg.row_byte[3:0]);
		state_next.col_g1 = smi_addr_bits(state_reg.col_byte[3:0]);
		// Identical groups: high nibbles are zero, so group two mirrors group one
		state_next.differ = (row_hi != 4'h0) || (col_hi != 4'h0);
		state_next.row_g2 = (row_hi == 4'h0) ? state_next.row_g1 : smi_addr_bits(row_hi);
		state_next.col_g2 = (col_hi == 4'h0) ? state_next.col_g1 : smi_addr_bits(col_hi);

		state_next.rows_undef = (state_reg.rows == 8'h00);
		width_v = {state_reg.width_hi, state_reg.width_lo};
		state_next.width = width_v;
		state_next.width_undef = (width_v == 16'h0000);

		case (state_reg.level)
			8'h00:             state_next.level_code = SMI_LVL_TTL5;
			8'h01:             state_next.level_code = SMI_LVL_LVTTL;
			8'h02:             state_next.level_code = SMI_LVL_HSTL15;
			8'h03:             state_next.level_code = SMI_LVL_SSTL33;
			8'h04:             state_next.level_code = SMI_LVL_SSTL25;
			SMI_LEVEL_NEW_TBL: state_next.level_code = SMI_LVL_NEW_TBL;
			default:           state_next.level_code = SMI_LVL_RESERVED;
		endcase

		state_next.period = smi_tenths(state_reg.cycle);
		state_next.acc_t = smi_tenths(state_reg.access);

		// ======================================================
		// AXI4-Lite write: only the control word's clear bit has an effect
		if (s_axi_awvalid && !state_reg.aw_held)
		begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.w_held)
		begin
			state_next.w_held = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_strb = s_axi_wstrb;
		end
		if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid)
		begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = SMI_RESP_OKAY;
			if (state_reg.aw_addr == SMI_ADDR_CTRL)
			begin
				// Restart collection; a byte latched this same cycle still counts
				if (state_reg.w_strb[0] && state_reg.w_data[0])
					state_next.seen = SMI_RESET_MASK | hit_v;
			end
			else if (state_reg.aw_addr > SMI_ADDR_CTRL || state_reg.aw_addr[1:0] != 2'b00)
				state_next.bresp = SMI_RESP_SLVERR;
			else
				state_next.bresp = SMI_RESP_SLVERR; // Decoded data are read-only
		end
		if (state_reg.bvalid && s_axi_bready)
			state_next.bvalid = 1'b0;

		// ======================================================
		// AXI4-Lite read
		if (s_axi_arvalid && !state_reg.rvalid)
		begin
			state_next.rvalid = 1'b1;
			state_next.rresp = SMI_RESP_OKAY;
			case (s_axi_araddr)
				SMI_ADDR_BYTES0: state_next.rdata = {state_reg.rows, state_reg.col_byte,
				                                    state_reg.row_byte, state_reg.mem_type};
				SMI_ADDR_BYTES1: state_next.rdata = {state_reg.cycle, state_reg.level,
				                                    state_reg.width_hi, state_reg.width_lo};
				SMI_ADDR_BYTES2: state_next.rdata = {16'h0000, state_reg.err_cfg, state_reg.access};
				SMI_ADDR_ROWCOL: state_next.rdata = {state_reg.differ, 2'b00,
				                                    state_reg.col_g2, 3'h0, state_reg.col_g1,
				                                    3'h0, state_reg.row_g2, 3'h0, state_reg.row_g1};
				SMI_ADDR_DECODE: state_next.rdata = {state_reg.width, 5'h00, state_reg.level_code,
				                                    2'b00, state_reg.width_undef, state_reg.rows_undef,
				                                    state_reg.type_unknown, state_reg.type_sdram,
				                                    state_reg.type_edo, state_reg.done};
				SMI_ADDR_TIMING: state_next.rdata = {16'h0000, state_reg.acc_t, state_reg.period};
				SMI_ADDR_CTRL:   state_next.rdata = {22'h000000, state_reg.seen};
				default:
				begin
					state_next.rdata = 32'h0000_0000;
					state_next.rresp = SMI_RESP_SLVERR;
				end
			endcase
		end
		else if (state_reg.rvalid && s_axi_rready)
			state_next.rvalid = 1'b0;

		// Registered readies keep every port straight off a flip-flop
		state_next.aw_rdy = !state_next.aw_held;
		state_next.w_rdy = !state_next.w_held;
		state_next.ar_rdy = !state_next.rvalid;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_reg <= SMI_STATE_RST;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// Outputs
	assign done_o              = state_reg.done;
	assign type_edo_o          = state_reg.type_edo;
	assign type_sdram_o        = state_reg.type_sdram;
	assign type_unknown_o      = state_reg.type_unknown;
	assign row_bits_g1_o       = state_reg.row_g1;
	assign row_bits_g2_o       = state_reg.row_g2;
	assign col_bits_g1_o       = state_reg.col_g1;
	assign col_bits_g2_o       = state_reg.col_g2;
	assign groups_differ_o     = state_reg.differ;
	assign module_rows_o       = state_reg.rows;
	assign rows_undefined_o    = state_reg.rows_undef;
	assign data_width_o        = state_reg.width;
	assign width_undefined_o   = state_reg.width_undef;
	assign signal_level_o      = state_reg.level_code;
	assign min_period_tenths_o = state_reg.period;
	assign max_access_tenths_o = state_reg.acc_t;
	assign error_scheme_o      = state_reg.err_cfg;
	assign s_axi_awready       = state_reg.aw_rdy;
	assign s_axi_wready        = state_reg.w_rdy;
	assign s_axi_bvalid        = state_reg.bvalid;
	assign s_axi_bresp         = state_reg.bresp;
	assign s_axi_arready       = state_reg.ar_rdy;
	assign s_axi_rvalid        = state_reg.rvalid;
	assign s_axi_rdata         = state_reg.rdata;
	assign s_axi_rresp         = state_reg.rresp;

endmodule : smi_decoder

// ===== test/smi_decoder_sva.sv
module smi_decoder_sva
	import smi_pkg::*;
(
	// Clock, reset and byte stream
	input  wire logic       clk_i, reset_n_i, byte_valid_i,
	input  wire logic [7:0] byte_index_i, byte_data_i,
	// Decoded results
	input  wire logic       done_o, type_edo_o, type_sdram_o, type_unknown_o,
	input  wire logic [4:0] row_bits_g1_o, row_bits_g2_o, col_bits_g1_o, col_bits_g2_o,
	input  wire logic [7:0] module_rows_o, min_period_tenths_o, max_access_tenths_o, error_scheme_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Helpers
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] d1, d2;
	// Byte as it stood two edges back, when its decoded value becomes visible
	always_ff @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			{d1, d2} <= 16'h0000;
		else
			{d1, d2} <= {byte_data_i, d1};
	function automatic logic [4:0] nib_bits(input logic [3:0] n);
		return (n == 4'h0) ? 5'h00 : (n <= SMI_ROLLUP_MAX) ? {1'b0, n} + SMI_ROLLUP_BASE : {1'b0, n};
	endfunction : nib_bits
	function automatic logic [7:0] tenths(input logic [7:0] b);
		return {4'h0, b[7:4]} * SMI_TENTHS_PER_NS + {4'h0, b[3:0]};
	endfunction : tenths
	// A repeat strobe on the next edge would legally overwrite, so it is excluded
	sequence s_once(logic [7:0] idx);
		byte_valid_i && byte_index_i == idx ##1 !(byte_valid_i && byte_index_i == idx);
	endsequence
	// ==========================================================
	// Properties
	property p_type;
		s_once(SMI_IDX_MEM_TYPE) |=> {type_edo_o, type_sdram_o, type_unknown_o} ==
			{d2 == SMI_TYPE_EDO, d2 == SMI_TYPE_SDRAM, d2 != SMI_TYPE_EDO && d2 != SMI_TYPE_SDRAM};
	endproperty
	property p_row;
		s_once(SMI_IDX_ROW_ADDR) |=> row_bits_g1_o == nib_bits(d2[3:0]) &&
			row_bits_g2_o == nib_bits((d2[7:4] == 4'h0) ? d2[3:0] : d2[7:4]);
	endproperty
	property p_col;
		s_once(SMI_IDX_COL_ADDR) |=> col_bits_g1_o == nib_bits(d2[3:0]) &&
			col_bits_g2_o == nib_bits((d2[7:4] == 4'h0) ? d2[3:0] : d2[7:4]);
	endproperty
	property p_rows;
		byte_valid_i && byte_index_i == SMI_IDX_ROWS |=> module_rows_o == $past(byte_data_i);
	endproperty
	property p_scheme;
		byte_valid_i && byte_index_i == SMI_IDX_ERR_CFG |=> error_scheme_o == $past(byte_data_i);
	endproperty
	property p_period;
		s_once(SMI_IDX_CYCLE) |=> min_period_tenths_o == tenths(d2);
	endproperty
	property p_access;
		s_once(SMI_IDX_ACCESS) |=> max_access_tenths_o == tenths(d2);
	endproperty
	property p_done;
		$rose(reset_n_i) |-> !done_o [*8];
	endproperty
	a_type: assert property (p_type) else $error("memory type flags wrong");
	a_row: assert property (p_row) else $error("row width wrong");
	a_col: assert property (p_col) else $error("column width wrong");
	a_rows: assert property (p_rows) else $error("module rows wrong");
	a_scheme: assert property (p_scheme) else $error("error scheme wrong");
	a_period: assert property (p_period) else $error("cycle time wrong");
	a_access: assert property (p_access) else $error("access time wrong");
	a_done: assert property (p_done) else $error("done too early");
endmodule : smi_decoder_sva

bind smi_decoder smi_decoder_sva smi_decoder_sva_inst (.*);

// ===== test/smi_spd_model.sv
module smi_spd_model
	import smi_pkg::*;
(
	// Control from the bench
	input  wire logic         clk_i, reset_n_i, start_i,
	input  wire logic [7:0]   first_i, last_i, gap_i,
	input  wire logic [103:0] image_i,
	// Byte stream toward the decoder
	output logic              byte_valid_o, busy_o,
	output logic [7:0]        byte_index_o, byte_data_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Fetch sequencer
	int idx;
	int idle;
	// Between strobes the lines toggle, so a stale byte never passes for a fresh one
	always @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			{busy_o, byte_valid_o, byte_index_o, byte_data_o} <= '0;
		else if (busy_o && idle >= gap_i)
		begin
			{byte_valid_o, byte_index_o, byte_data_o} <= {1'b1, 8'(idx), image_i[idx*8 +: 8]};
			busy_o <= (idx != last_i);
			idx = idx + 1;
			idle = 0;
		end
		else
		begin
			{byte_valid_o, byte_index_o, byte_data_o} <= {1'b0, ~byte_index_o, ~byte_data_o};
			busy_o <= busy_o | start_i;
			idle = start_i ? gap_i : idle + 1;
			if (!busy_o)
				idx = first_i;
		end
endmodule : smi_spd_model

// ===== test/test_sdram_module_info_decoder.sv
module test_sdram_module_info_decoder
	import smi_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, reset_n_i = 0, byte_valid_i, done_o, type_edo_o, type_sdram_o, type_unknown_o, groups_differ_o;
	logic rows_undefined_o, width_undefined_o, s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid, s_axi_rready = 0;
	logic [7:0] byte_index_i, byte_data_i, module_rows_o, min_period_tenths_o, max_access_tenths_o, error_scheme_o;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, first_idx = 8'h00, last_idx = 8'h00, gap = 8'h00;
	logic [4:0] row_bits_g1_o, row_bits_g2_o, col_bits_g1_o, col_bits_g2_o;
	logic [2:0] signal_level_o;
	logic [15:0] data_width_o;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [103:0] image = '0;
	logic start = 0, busy;
	logic [7:0] types[3] = '{8'h02, 8'h04, 8'h07};
	logic [7:0] levels[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hFF, 8'h05};
	int err_count = 0, checks_done = 0, cycles = 0, seed = 32'h6226;

	smi_decoder smi_decoder_inst (.*);
	smi_spd_model smi_spd_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start), .first_i(first_idx),
		.last_i(last_idx), .gap_i(gap), .image_i(image), .byte_valid_o(byte_valid_i), .busy_o(busy),
		.byte_index_o(byte_index_i), .byte_data_o(byte_data_i));

	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			err_count++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask : check
	function automatic int nib(input int n);
		return (n == 0) ? 0 : (n < 4) ? n + 15 : n;
	endfunction : nib
	task automatic load(input int lo, input int hi, input int g);
		@(posedge clk_i);
		{first_idx, last_idx, gap, start} <= {lo[7:0], hi[7:0], g[7:0], 1'b1};
		@(posedge clk_i);
		start <= 1'b0;
		do @(posedge clk_i); while (busy !== 1'b0);
		repeat (3) @(posedge clk_i);
		#1;
	endtask : load
	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk_i);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do
		begin
			@(posedge clk_i);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		{rd, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do
		begin
			@(posedge clk_i);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	// Behavioural reference for every decoded output
	task automatic check_all();
		int b[13];
		int r2;
		int c2;
		int lvl;
		for (int i = 0; i < 13; i++)
			b[i] = image[i*8 +: 8];
		r2 = nib(b[3] < 16 ? b[3] % 16 : b[3] / 16);
		c2 = nib(b[4] < 16 ? b[4] % 16 : b[4] / 16);
		lvl = b[8] < 5 ? b[8] : b[8] == 255 ? 5 : 6;
		check(done_o, 1);
		check({type_edo_o, type_sdram_o, type_unknown_o}, {b[2] == 2, b[2] == 4, b[2] != 2 && b[2] != 4});
		check(row_bits_g1_o, nib(b[3] % 16));
		check(row_bits_g2_o, r2);
		check(col_bits_g1_o, nib(b[4] % 16));
		check(col_bits_g2_o, c2);
		check(groups_differ_o, b[3] > 15 || b[4] > 15);
		check({rows_undefined_o, module_rows_o}, {b[5] == 0, 8'(b[5])});
		check({width_undefined_o, data_width_o}, {b[6] + b[7] == 0, 16'(b[7] * 256 + b[6])});
		check(signal_level_o, lvl);
		check(min_period_tenths_o, b[9] / 16 * 10 + b[9] % 16);
		check(max_access_tenths_o, b[10] / 16 * 10 + b[10] % 16);
		check(error_scheme_o, b[11]);
		axi_rd(SMI_ADDR_BYTES0);
		check(rd, {b[5][7:0], b[4][7:0], b[3][7:0], b[2][7:0]});
		axi_rd(SMI_ADDR_BYTES1);
		check(rd, {b[9][7:0], b[8][7:0], b[7][7:0], b[6][7:0]});
		axi_rd(SMI_ADDR_BYTES2);
		check(rd, {16'h0000, b[11][7:0], b[10][7:0]});
		axi_rd(SMI_ADDR_ROWCOL);
		check(rd, (b[3] > 15 || b[4] > 15) << 31 | c2 << 24 | nib(b[4] % 16) << 16 | r2 << 8 | nib(b[3] % 16));
		axi_rd(SMI_ADDR_DECODE);
		check(rd, (b[7] * 256 + b[6]) << 16 | lvl << 8 | (b[6] + b[7] == 0) << 5 | (b[5] == 0) << 4
			| (b[2] != 2 && b[2] != 4) << 3 | (b[2] == 4) << 2 | (b[2] == 2) << 1 | 1);
		axi_rd(SMI_ADDR_TIMING);
		check(rd, (b[10] / 16 * 10 + b[10] % 16) << 8 | b[9] / 16 * 10 + b[9] % 16);
	endtask : check_all
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_i);
		check({done_o, s_axi_awready, s_axi_wready, s_axi_arready}, 4'h7);
		reset_n_i <= 1'b1;
		for (int it = 0; it < 14; it++)
		begin
			@(posedge clk_i);
			for (int i = 0; i < 13; i++)
				image[i*8 +: 8] <= $random(seed);
			image[16 +: 8] <= types[it % 3];
			image[24 +: 8] <= {2'b00, 2'($random(seed)), 4'($random(seed))};
			image[32 +: 8] <= {2'b00, 2'($random(seed)), 4'($random(seed))};
			image[64 +: 8] <= levels[it % 7];
			if (it == 1)
				image[40 +: 24] <= 24'h000000;
			// Indices 0, 1 and 12 are sent too and must be ignored
			load(0, 12, $random(seed) & 3);
			check_all();
		end
		axi_rd(8'h1C);
		check(rd, 32'h0);
		check(rs, SMI_RESP_SLVERR);
		axi_wr(SMI_ADDR_BYTES0, 32'h1);
		check({rs, done_o}, {SMI_RESP_SLVERR, 1'b1});
		axi_wr(SMI_ADDR_CTRL, 32'h1);
		repeat (3) @(posedge clk_i);
		check({rs, done_o}, {SMI_RESP_OKAY, 1'b0});
		load(2, 10, 1);
		check(done_o, 0);
		axi_rd(SMI_ADDR_CTRL);
		check(rd, 32'h1FF);
		load(11, 11, 0);
		check(done_o, 1);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check(done_o, 0);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check({done_o, s_axi_awready, s_axi_wready, s_axi_arready}, 4'h7);
		report_and_stop();
	end
endmodule : test_sdram_module_info_decoder
